/* File: core/power_loss_timer.sv */
// power-loss timer: counts cycles of lost supply and flags the loss
// assumes powered and fullSpeed are already synchronised to ref_clk
`timescale 1ns/100ps
`default_nettype none
module power_loss_timer (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic powered,
	input wire logic fullSpeed,
	output logic lost
);

	logic [usb_iso_pkg::TMR_W-1:0] count;
	logic [usb_iso_pkg::TMR_W-1:0] next_count;
	logic [usb_iso_pkg::TMR_W-1:0] limit;
	logic next_lost;

	// window scales with the bit time of the selected speed
	assign limit = fullSpeed ? usb_iso_pkg::LOSS_LIM_FS : usb_iso_pkg::LOSS_LIM_LS;

	// short dips shorter than the window are ridden through
	always_comb begin
		next_count = count;
		next_lost = lost;
		if (powered) begin
			next_count = '0;
			next_lost = 1'b0;
		end else if (count >= limit) begin
			next_lost = 1'b1;
		end else begin
			next_count = count + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			count <= '0;
			lost <= 1'b0;
		end else begin
			count <= next_count;
			lost <= next_lost;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	loss_at_limit_a: assert property ($rose(lost) |-> count == limit && !$past(powered))
		else $error("loss flagged away from its speed limit");

endmodule // power_loss_timer
`default_nettype wire

/* File: core/usb_iso_port_ctrl.sv */
// port control of a two-sided low/full speed usb isolator
// assumes pins and straps are asynchronous; drive requests come from
// forwarding logic on ref_clk; registers are reached over apb
//
// Functional notes
// - downstream speed strap selects downstream buffer speed
// - pull-up enable powers upstream pull-up
// - enable low: both pairs float, upstream detached
// - upstream power lost: downstream floats within 32 bits
// - downstream drivers start in high impedance
// - downstream power lost: upstream detaches within 32 bits
// - upstream speed strap selects upstream buffer speed
`timescale 1ns/100ps
`default_nettype none
module usb_iso_port_ctrl (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic upstreamPowerGood,
	input wire logic downstreamPowerGood,
	input wire logic upstreamSpeedStrap,
	input wire logic downstreamSpeedStrap,
	input wire logic pullupEnable,
	input wire logic upstreamDriveReq,
	input wire logic upstreamTxDp,
	input wire logic upstreamTxDm,
	input wire logic downstreamDriveReq,
	input wire logic downstreamTxDp,
	input wire logic downstreamTxDm,
	input wire logic upstreamDpIn,
	input wire logic upstreamDmIn,
	input wire logic downstreamDpIn,
	input wire logic downstreamDmIn,
	output logic upstreamDpOut,
	output logic upstreamDpOe,
	output logic upstreamDmOut,
	output logic upstreamDmOe,
	output logic downstreamDpOut,
	output logic downstreamDpOe,
	output logic downstreamDmOut,
	output logic downstreamDmOe,
	output logic upstreamPullup,
	output logic upstreamFullSpeed,
	output logic downstreamFullSpeed,
	output logic speedMismatch
);

	logic [8:0] rawIn;
	logic [8:0] syncMeta;
	logic [8:0] syncIn;
	logic upPwr;
	logic downPwr;
	logic upStrap;
	logic downStrap;
	logic pinLevel;
	logic [1:0] upLine;
	logic [1:0] downLine;
	logic upLost;
	logic downLost;
	usb_iso_pkg::link_state_t state;
	usb_iso_pkg::link_state_t next_state;
	logic holdOff;
	logic next_holdOff;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_upDrive;
	logic next_downDrive;
	logic next_pullup;

	// every asynchronous input passes two flops before the port logic reads it; only the check helpers below read raw pins
	assign rawIn = {upstreamPowerGood, downstreamPowerGood, upstreamSpeedStrap,
		downstreamSpeedStrap, pullupEnable, upstreamDpIn, upstreamDmIn,
		downstreamDpIn, downstreamDmIn};

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			syncMeta <= '0;
			syncIn <= '0;
		end else begin
			syncMeta <= rawIn;
			syncIn <= syncMeta;
		end
	end

	assign {upPwr, downPwr, upStrap, downStrap, pinLevel, upLine, downLine} = syncIn;

	// upstream loss is timed in downstream bit times and the reverse
	power_loss_timer upLossTimer (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.powered(upPwr),
		.fullSpeed(downStrap),
		.lost(upLost)
	);

	power_loss_timer downLossTimer (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.powered(downPwr),
		.fullSpeed(upStrap),
		.lost(downLost)
	);

	// port state: attach follows the enable pin unless software holds off
	always_comb begin
		next_state = state;
		unique case (state)
			usb_iso_pkg::ST_INIT: begin
				if (upPwr && downPwr) begin
					next_state = usb_iso_pkg::ST_DETACHED;
				end
			end
			usb_iso_pkg::ST_DETACHED: begin
				if (upLost || downLost) begin
					next_state = usb_iso_pkg::ST_LOSS;
				end else if (pinLevel && !holdOff) begin
					next_state = usb_iso_pkg::ST_ATTACHED;
				end
			end
			usb_iso_pkg::ST_ATTACHED: begin
				if (upLost || downLost) begin
					next_state = usb_iso_pkg::ST_LOSS;
				end else if (!pinLevel || holdOff) begin
					next_state = usb_iso_pkg::ST_DETACHED;
				end
			end
			usb_iso_pkg::ST_LOSS: begin
				// return only through detached, so attach is always re-timed
				if (upPwr && downPwr && !upLost && !downLost) begin
					next_state = usb_iso_pkg::ST_DETACHED;
				end
			end
			default: begin
				next_state = usb_iso_pkg::ST_INIT;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state <= usb_iso_pkg::ST_INIT;
		end else begin
			state <= next_state;
		end
	end

	// drivers and pull-up only while attached, decided from the next state
	// so a loss takes the pins off in the same edge as the state change
	always_comb begin
		next_pullup = (next_state == usb_iso_pkg::ST_ATTACHED);
		next_upDrive = next_pullup && upstreamDriveReq;
		next_downDrive = next_pullup && downstreamDriveReq;
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			upstreamPullup <= 1'b0;
			upstreamDpOe <= 1'b0;
			upstreamDmOe <= 1'b0;
			downstreamDpOe <= 1'b0;
			downstreamDmOe <= 1'b0;
			upstreamDpOut <= 1'b0;
			upstreamDmOut <= 1'b0;
			downstreamDpOut <= 1'b0;
			downstreamDmOut <= 1'b0;
		end else begin
			upstreamPullup <= next_pullup;
			upstreamDpOe <= next_upDrive;
			upstreamDmOe <= next_upDrive;
			downstreamDpOe <= next_downDrive;
			downstreamDmOe <= next_downDrive;
			upstreamDpOut <= upstreamTxDp;
			upstreamDmOut <= upstreamTxDm;
			downstreamDpOut <= downstreamTxDp;
			downstreamDmOut <= downstreamTxDm;
		end
	end

	// buffer speed selects; straps are static, a mismatch is only reported
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			upstreamFullSpeed <= 1'b0;
			downstreamFullSpeed <= 1'b0;
			speedMismatch <= 1'b0;
		end else begin
			upstreamFullSpeed <= upStrap;
			downstreamFullSpeed <= downStrap;
			speedMismatch <= upStrap ^ downStrap;
		end
	end

	// apb slave with one wait state; writes land on the pready edge
	always_comb begin
		next_pready = psel && penable && !pready;
		next_pslverr = 1'b0;
		next_prdata = '0;
		next_holdOff = holdOff;
		if (psel && penable && !pready) begin
			if (paddr == usb_iso_pkg::CTRL_OFS) begin
				next_prdata[usb_iso_pkg::CTRL_HOLD_OFF] = holdOff;
			end else if (paddr == usb_iso_pkg::STATUS_OFS) begin
				next_prdata[usb_iso_pkg::SB_UP_PWR] = upPwr;
				next_prdata[usb_iso_pkg::SB_DOWN_PWR] = downPwr;
				next_prdata[usb_iso_pkg::SB_UP_FS] = upStrap;
				next_prdata[usb_iso_pkg::SB_DOWN_FS] = downStrap;
				next_prdata[usb_iso_pkg::SB_MISMATCH] = upStrap ^ downStrap;
				next_prdata[usb_iso_pkg::SB_PIN_LEVEL] = pinLevel;
				next_prdata[usb_iso_pkg::SB_PULLUP] = upstreamPullup;
				next_prdata[usb_iso_pkg::SB_STATE_LO +: 4] = state;
				next_prdata[usb_iso_pkg::SB_UP_LINE_LO +: 2] = upLine;
				next_prdata[usb_iso_pkg::SB_DOWN_LINE_LO +: 2] = downLine;
				next_prdata[usb_iso_pkg::SB_UP_LOST] = upLost;
				next_prdata[usb_iso_pkg::SB_DOWN_LOST] = downLost;
				next_pslverr = pwrite; // status is read-only
			end else begin
				next_pslverr = 1'b1; // unmapped
			end
		end
		if (psel && penable && pready && pwrite && paddr == usb_iso_pkg::CTRL_OFS) begin
			next_holdOff = pwdata[usb_iso_pkg::CTRL_HOLD_OFF];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
			holdOff <= usb_iso_pkg::CTRL_HOLD_OFF_RST;
		end else begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
			holdOff <= next_holdOff;
		end
	end

	// helper counters read only by the checks below
	logic [2:0] settleCnt;
	logic [usb_iso_pkg::TMR_W:0] upOffCnt;
	logic [usb_iso_pkg::TMR_W:0] downOffCnt;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			settleCnt <= '0;
			upOffCnt <= '0;
			downOffCnt <= '0;
		end else begin
			settleCnt <= (settleCnt == 3'h4) ? settleCnt : settleCnt + 3'h1;
			upOffCnt <= upstreamPowerGood ? '0 : (&upOffCnt ? upOffCnt : upOffCnt + 1'b1);
			downOffCnt <= downstreamPowerGood ? '0 :
				(&downOffCnt ? downOffCnt : downOffCnt + 1'b1);
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	down_speed_a: assert property (settleCnt == 3'h4 |->
		downstreamFullSpeed == $past(downstreamSpeedStrap, 3))
		else $error("downstream speed select does not follow its strap");

	up_speed_a: assert property (settleCnt == 3'h4 |->
		upstreamFullSpeed == $past(upstreamSpeedStrap, 3))
		else $error("upstream speed select does not follow its strap");

	// pull-up at this edge was decided one edge back, with holdOff as it stood then
	pullup_cause_a: assert property (upstreamPullup |->
		$past(pullupEnable, 3) && !$past(holdOff))
		else $error("pull-up on without the enable pin");

	detach_float_a: assert property (settleCnt == 3'h4 && !$past(pullupEnable, 3) |->
		!upstreamPullup && !upstreamDpOe && !upstreamDmOe && !downstreamDpOe && !downstreamDmOe)
		else $error("drivers or pull-up active with enable low");

	up_loss_float_a: assert property (upOffCnt >= {1'b0, downstreamFullSpeed ?
		usb_iso_pkg::LOSS_CYC_FS_C : usb_iso_pkg::LOSS_CYC_LS_C} |->
		!downstreamDpOe && !downstreamDmOe)
		else $error("downstream still driven after upstream power loss");

	down_loss_detach_a: assert property (downOffCnt >= {1'b0, upstreamFullSpeed ?
		usb_iso_pkg::LOSS_CYC_FS_C : usb_iso_pkg::LOSS_CYC_LS_C} |->
		!upstreamPullup && !upstreamDpOe && !upstreamDmOe)
		else $error("upstream still attached after downstream power loss");

	init_float_a: assert property (settleCnt < 3'h3 |->
		!downstreamDpOe && !downstreamDmOe && !upstreamPullup)
		else $error("drivers active straight out of reset");

	attach_timing_a: assert property ($rose(upstreamPullup) |->
		$past(state) == usb_iso_pkg::ST_DETACHED && !$past(upLost) && !$past(downLost))
		else $error("attach taken from a state other than detached");

	attach_c: cover property ($rose(upstreamPullup));
	up_loss_c: cover property ($rose(upLost) ##[1:4] state == usb_iso_pkg::ST_LOSS);
	down_loss_c: cover property ($rose(downLost) ##[1:4] !upstreamPullup);
	mismatch_c: cover property ($rose(speedMismatch));

endmodule // usb_iso_port_ctrl
`default_nettype wire

/* File: pkg/usb_iso_pkg.sv */
// constants, register map and state codes for the isolator port control
// assumes one 100 MHz clock and a 32-bit apb register port
package usb_iso_pkg;

	// clock and bit rates, in hertz
	localparam longint unsigned CLK_HZ = 64'h0000_0000_05f5_e100;
	localparam longint unsigned FS_BIT_HZ = 64'h0000_0000_00b7_1b00;
	localparam longint unsigned LS_BIT_HZ = 64'h0000_0000_0016_e360;

	// power-loss window, in bit times of the selected speed
	localparam longint unsigned LOSS_BIT_TIMES = 64'h0000_0000_0000_0020;

	// longest window in clock cycles, rounded down
	localparam longint unsigned LOSS_CYC_FS = (CLK_HZ * LOSS_BIT_TIMES) / FS_BIT_HZ;
	localparam longint unsigned LOSS_CYC_LS = (CLK_HZ * LOSS_BIT_TIMES) / LS_BIT_HZ;

	// cycles spent in synchroniser, timer lost-flag and output flops around the count
	localparam longint unsigned LOSS_LATENCY = 64'h0000_0000_0000_0004;

	// timer width and thresholds
	localparam int TMR_W = 12;
	localparam logic [TMR_W-1:0] LOSS_CYC_FS_C = TMR_W'(LOSS_CYC_FS);
	localparam logic [TMR_W-1:0] LOSS_CYC_LS_C = TMR_W'(LOSS_CYC_LS);
	localparam logic [TMR_W-1:0] LOSS_LIM_FS = TMR_W'(LOSS_CYC_FS - LOSS_LATENCY);
	localparam logic [TMR_W-1:0] LOSS_LIM_LS = TMR_W'(LOSS_CYC_LS - LOSS_LATENCY);

	// register offsets (byte addresses)
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;

	// control register fields and reset value
	localparam int CTRL_HOLD_OFF = 0;
	localparam logic CTRL_HOLD_OFF_RST = 1'h0;

	// status register fields
	localparam int SB_UP_PWR = 0;
	localparam int SB_DOWN_PWR = 1;
	localparam int SB_UP_FS = 2;
	localparam int SB_DOWN_FS = 3;
	localparam int SB_MISMATCH = 4;
	localparam int SB_PIN_LEVEL = 5;
	localparam int SB_PULLUP = 6;
	localparam int SB_STATE_LO = 8;
	localparam int SB_UP_LINE_LO = 12;
	localparam int SB_DOWN_LINE_LO = 14;
	localparam int SB_UP_LOST = 16;
	localparam int SB_DOWN_LOST = 17;

	// port states, one-hot
	typedef enum logic [3:0] {
		ST_INIT = 4'h1,
		ST_DETACHED = 4'h2,
		ST_ATTACHED = 4'h4,
		ST_LOSS = 4'h8
	} link_state_t;

endpackage

/* File: verif/periph_model.sv */
// peripheral-side model: downstream speed strap, pull-up enable, drive
// assumes the bench's clock; the strap changes only while in reset
`timescale 1ns/100ps
`default_nettype none
module periph_model (
	input wire logic ref_clk,
	input wire logic fullSpeed,
	input wire logic attach,
	input wire logic txReq,
	output logic speedStrap,
	output logic pullupEnable,
	output logic driveReq,
	output logic txDp,
	output logic txDm
);
	logic toggle;
	logic next_toggle;
	// strap is a tied level, never moved by traffic
	assign speedStrap = fullSpeed;
	// alternate k and j while sending; released lines fall to the pull-down
	always_comb begin
		// an unknown start counts as low, so the pattern settles at once
		next_toggle = txReq ? (toggle !== 1'b1) : 1'b0;
	end
	always_ff @(posedge ref_clk) begin
		toggle <= next_toggle;
		pullupEnable <= attach;
		driveReq <= txReq;
		txDp <= txReq & ~toggle;
		txDm <= txReq & toggle;
	end
endmodule // periph_model
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the isolator port control
// assumes the peripheral model beside it and the design's package
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic fullSel, attach, txReq, upstreamPowerGood, downstreamPowerGood;
	logic upstreamSpeedStrap, downstreamSpeedStrap, pullupEnable;
	logic upstreamDriveReq, upstreamTxDp, upstreamTxDm;
	logic downstreamDriveReq, downstreamTxDp, downstreamTxDm;
	logic upstreamDpIn, upstreamDmIn, downstreamDpIn, downstreamDmIn;
	logic upstreamDpOut, upstreamDpOe, upstreamDmOut, upstreamDmOe;
	logic downstreamDpOut, downstreamDpOe, downstreamDmOut, downstreamDmOe;
	logic upstreamPullup, upstreamFullSpeed, downstreamFullSpeed, speedMismatch;
	int errorCnt, comparisons;

	// wire levels: an enabled driver wins, else pull-up or released peripheral
	assign upstreamDpIn = upstreamDpOe ? upstreamDpOut : upstreamPullup & upstreamFullSpeed;
	assign upstreamDmIn = upstreamDmOe ? upstreamDmOut : upstreamPullup & ~upstreamFullSpeed;
	assign downstreamDpIn = downstreamDpOe ? downstreamDpOut : downstreamTxDp;
	assign downstreamDmIn = downstreamDmOe ? downstreamDmOut : downstreamTxDm;

	usb_iso_port_ctrl dut (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .upstreamPowerGood, .downstreamPowerGood,
		.upstreamSpeedStrap, .downstreamSpeedStrap, .pullupEnable, .upstreamDriveReq,
		.upstreamTxDp, .upstreamTxDm, .downstreamDriveReq, .downstreamTxDp,
		.downstreamTxDm, .upstreamDpIn, .upstreamDmIn, .downstreamDpIn, .downstreamDmIn,
		.upstreamDpOut, .upstreamDpOe, .upstreamDmOut, .upstreamDmOe, .downstreamDpOut,
		.downstreamDpOe, .downstreamDmOut, .downstreamDmOe, .upstreamPullup,
		.upstreamFullSpeed, .downstreamFullSpeed, .speedMismatch);

	periph_model peer (.ref_clk, .fullSpeed(fullSel), .attach, .txReq,
		.speedStrap(downstreamSpeedStrap), .pullupEnable, .driveReq(downstreamDriveReq),
		.txDp(downstreamTxDp), .txDm(downstreamTxDm));

	// free-running 100 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errorCnt++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask

	// apb transfer; waits on pready for as long as it takes, the watchdog ends a hang
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// straps move only under reset, as a board would be strapped
	task rst(input logic up, input logic down);
		@(posedge ref_clk);
		resetn <= 1'b0;
		upstreamSpeedStrap <= up;
		fullSel <= down;
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (20) @(posedge ref_clk);
	endtask

	// drop one supply and count cycles until the far side lets go
	task loss(input logic up, input int lim);
		int n;
		n = 0;
		chk1(up ? downstreamDpOe : upstreamPullup, 1'b1);
		@(posedge ref_clk);
		if (up)
			upstreamPowerGood <= 1'b0;
		else
			downstreamPowerGood <= 1'b0;
		do begin
			@(posedge ref_clk);
			n++;
		end while ((up ? downstreamDpOe | downstreamDmOe :
			upstreamPullup | upstreamDpOe | upstreamDmOe) && n <= lim + 1);
		// the release lands just after edge n-1; edge n is the first to sample it
		chk1(n - 1 <= lim, 1'b1);
		chk1(n > lim / 2, 1'b1);
		upstreamPowerGood <= 1'b1;
		downstreamPowerGood <= 1'b1;
		repeat (20) @(posedge ref_clk);
	endtask

	task t_regs;
		chk1(upstreamPullup | upstreamDpOe | downstreamDpOe | downstreamDmOe, 1'b0);
		apb(1'b0, usb_iso_pkg::CTRL_OFS, 32'h0);
		chk(rd, 32'h0);
		chk1(err, 1'b0);
		apb(1'b0, usb_iso_pkg::STATUS_OFS, 32'h0);
		chk(rd & 32'hffff_3fff, 32'h0000_020f);
		apb(1'b1, usb_iso_pkg::STATUS_OFS, 32'hffff_ffff);
		chk1(err, 1'b1);
		apb(1'b0, 8'h08, 32'h0);
		chk1(err, 1'b1);
		chk(rd, 32'h0);
		$display("registers done");
	endtask

	task t_attach;
		logic prevDp, prevDm;
		upstreamDriveReq <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk1(upstreamPullup | upstreamDpOe | downstreamDpOe, 1'b0);
		attach <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk1(upstreamPullup, 1'b1);
		chk1(upstreamDpOe & upstreamDmOe & downstreamDpOe & downstreamDmOe, 1'b1);
		chk1(upstreamDpOut & ~upstreamDmOut, 1'b1);
		// downstream data out is the peripheral's tx level one edge later
		prevDp = downstreamTxDp;
		prevDm = downstreamTxDm;
		@(posedge ref_clk);
		chk1(downstreamDpOut, prevDp);
		chk1(downstreamDmOut, prevDm);
		apb(1'b1, usb_iso_pkg::CTRL_OFS, 32'h1);
		apb(1'b0, usb_iso_pkg::CTRL_OFS, 32'h0);
		chk(rd, 32'h1);
		repeat (5) @(posedge ref_clk);
		chk1(upstreamPullup | upstreamDpOe | downstreamDpOe, 1'b0);
		apb(1'b1, usb_iso_pkg::CTRL_OFS, 32'h0);
		repeat (10) @(posedge ref_clk);
		$display("attach done");
	endtask

	task t_speed;
		chk1(upstreamFullSpeed & downstreamFullSpeed & ~speedMismatch, 1'b1);
		loss(1'b1, int'(usb_iso_pkg::LOSS_CYC_FS));
		loss(1'b0, int'(usb_iso_pkg::LOSS_CYC_FS));
		rst(1'b0, 1'b0);
		chk1(upstreamFullSpeed | downstreamFullSpeed | speedMismatch, 1'b0);
		loss(1'b1, int'(usb_iso_pkg::LOSS_CYC_LS));
		rst(1'b1, 1'b0);
		chk1(upstreamFullSpeed & ~downstreamFullSpeed & speedMismatch, 1'b1);
		$display("speed and loss done");
	endtask

	task closeOut;
		$display("errors %0d comparisons %0d", errorCnt, comparisons);
		if (errorCnt == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// main sequence; the downstream driver requesting from time zero tests the quiet start
	initial begin
		errorCnt = 0;
		comparisons = 0;
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		upstreamPowerGood = 1'b1;
		downstreamPowerGood = 1'b1;
		upstreamSpeedStrap = 1'b1;
		fullSel = 1'b1;
		attach = 1'b0;
		txReq = 1'b1;
		upstreamDriveReq = 1'b0;
		upstreamTxDp = 1'b1;
		upstreamTxDm = 1'b0;
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (10) @(posedge ref_clk);
		t_regs;
		t_attach;
		t_speed;
		closeOut;
	end

	// watchdog well beyond the longest low speed window plus traffic
	initial begin
		repeat (20000) @(posedge ref_clk);
		errorCnt++;
		closeOut;
	end
endmodule // testbench
`default_nettype wire
